// *** occ_pkg.sv ***
// Package with register layout, reset values, clock codes and timing for the oscillator control block.
package occ_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [11:0] OCC_ADDR_CONTROL = 12'h000;
	localparam logic [11:0] OCC_ADDR_STATUS = 12'h004;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int OCC_POS_PLL = 7;
	localparam int OCC_POS_FREQ_LO = 3;
	localparam int OCC_POS_SRC_LO = 0;
	localparam logic RST_SOFT_PLL = 1'b0;
	localparam logic [3:0] RST_FREQ_SEL = 4'h7;
	localparam logic [1:0] RST_SRC_SEL = 2'h0;

	// ---------------------------------------------------------------
	// Clock choice codes handed to the clock switch
	// ---------------------------------------------------------------
	localparam logic [2:0] CLK_LOW_31K = 3'h0;
	localparam logic [2:0] CLK_MED = 3'h1;
	localparam logic [2:0] CLK_HIGH = 3'h2;
	localparam logic [2:0] CLK_EXT = 3'h3;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int OCC_CLK_PERIOD_NS = 50;
	localparam int STARTUP_CYCLES_DEFAULT = 1024;
	localparam int OCC_SYNC_STAGES = 3;

	// Software visible fields grouped together.
	typedef struct packed {
		logic soft_pll_enable;
		logic [3:0] int_osc_freq_select;
		logic [1:0] sysclk_source_select;
	} occ_ctrl_s;

	// Decoded clock request going to the glitch free switch.
	typedef struct packed {
		logic [2:0] source;
		logic [3:0] freq_code;
		logic pll_on;
	} occ_clk_req_s;

	typedef enum logic [2:0] {
		OCC_ST_INT = 3'b001,
		OCC_ST_WAIT = 3'b010,
		OCC_ST_EXT = 3'b100
	} occ_state_e;

endpackage

// *** occ_clk_switch.sv ***
// Glitch free clock selection handshake: one request is applied only after the old one is gated off.
`timescale 1ns/100ps
`default_nettype none
module occ_clk_switch
	import occ_pkg::*;
(
	input wire logic core_clk, // System clock.
	input wire logic rst, // Synchronous reset, high.
	input wire occ_clk_req_s req, // Requested clock.
	output occ_clk_req_s active, // Clock now applied.
	output logic gate_off // High while the output clock is held off.
);

	typedef struct packed {
		occ_clk_req_s cur;
		logic gated;
	} occ_sw_s;

	occ_sw_s st;
	occ_sw_s next_st;

	// A change first gates the clock for a cycle, then loads the new choice, so no short pulse escapes.
	always_comb
	begin
		next_st = st;
		if (st.gated)
		begin
			next_st.cur = req;
			next_st.gated = 1'b0;
		end
		else if (req != st.cur)
		begin
			next_st.gated = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st.cur <= '{source: CLK_MED, freq_code: RST_FREQ_SEL, pll_on: 1'b0};
			st.gated <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign active = st.cur;
	assign gate_off = st.gated;

	// The applied choice never changes unless the clock was gated the cycle before.
	a_switch_gated: assert property (@(posedge core_clk) disable iff (rst)
		(active != $past(active)) |-> $past(gate_off)) else $error("clock choice changed ungated");

endmodule
`default_nettype wire

// *** occ_top.sv ***
// Oscillator control register with APB access, PLL control, source decode, start-up timer and fail handling.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Configuration PLL force set keeps the times four multiplier on for code 1110 or the external source, ignoring software.
// - Without force, software PLL enable bit turns the multiplier on or off for those same cases.
// - Frequency select lives in bits 6 to 3; codes 000x pick 31 kHz low oscillator.
// - Codes 0010 and 0011 both give 31.25 kHz from the medium oscillator.
// - Code 1011 gives 1 MHz, code 1100 gives 2 MHz, from high oscillator.
// - Code 1110 gives 8 MHz, or 32 MHz when the multiplier is on.
// - Reset loads frequency select with 0111.
// - Source select in bits 1 to 0; 1x runs from internal oscillator block.
// - Source select 0x runs from the configured oscillator mode.
// - Bit 2 reads zero and ignores writes.
// - PLL enable and source select bits are read-write and reset to zero.
// - Changing source select restarts start-up timer; internal clock runs until expiry.
// - External clock failure falls back to internal clock at selected frequency.
module occ_top
	import occ_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEFAULT // Start-up timer length in cycles.
)
(
	input wire logic core_clk, // System clock, 20 MHz.
	input wire logic rst, // Synchronous reset, high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic config_pll_force, // Nonvolatile PLL force setting.
	input wire logic [2:0] config_osc_mode, // Nonvolatile oscillator mode.
	input wire logic ext_clk_fail, // External clock failure, asynchronous.
	output logic times_four_multiplier, // Multiplier enable.
	output logic [2:0] clk_source, // Applied clock source code.
	output logic [3:0] clk_freq_code, // Applied internal frequency code.
	output logic [2:0] clk_mode, // Oscillator mode for the external source.
	output logic clk_gate_off, // Output clock held off during a switch.
	output logic osc_fail_flag // Fail-safe condition active.
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		occ_ctrl_s ctrl;
		occ_state_e fsm;
		logic [15:0] startup_count;
		logic fail;
		logic [2:0] fail_sync;
		logic [31:0] rdata;
		logic err;
	} occ_state_s;

	occ_state_s st;
	occ_state_s next_st;
	occ_clk_req_s req;
	occ_clk_req_s active;
	logic wr_ctrl;
	logic acc;
	logic mapped;
	logic fail_seen;
	logic src_change;
	logic pll_on;

	localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);

	// Maps a frequency code to the oscillator that feeds it.
	function automatic logic [2:0] occ_osc_of(input logic [3:0] code);
		logic [2:0] r;
		r = CLK_HIGH;
		if (code[3:1] == 3'h0)
			r = CLK_LOW_31K;
		else if (code[3] == 1'b0)
			r = CLK_MED;
		else
			r = CLK_HIGH;
		return r;
	endfunction

	// Packs the control fields into the register image; bit 2 stays zero.
	function automatic logic [31:0] occ_image(input occ_ctrl_s c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[OCC_POS_PLL] = c.soft_pll_enable;
		v[OCC_POS_FREQ_LO +: 4] = c.int_osc_freq_select;
		v[OCC_POS_SRC_LO +: 2] = c.sysclk_source_select;
		return v;
	endfunction

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// Zero wait states keep the software side simple; every access finishes in its first access cycle.
	assign acc = psel && penable;
	assign mapped = (paddr == OCC_ADDR_CONTROL) || (paddr == OCC_ADDR_STATUS);
	assign wr_ctrl = acc && pwrite && (paddr == OCC_ADDR_CONTROL);
	assign pready = 1'b1;
	assign src_change = wr_ctrl && (pwdata[OCC_POS_SRC_LO +: 2] != st.ctrl.sysclk_source_select);
	assign fail_seen = st.fail_sync[1] && st.fail_sync[2];

	// Force overrides the software bit; otherwise the software bit decides.
	assign pll_on = config_pll_force ? 1'b1 : st.ctrl.soft_pll_enable;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.fail_sync = {st.fail_sync[1:0], ext_clk_fail};
		next_st.err = 1'b0;
		next_st.rdata = 32'h0000_0000;
		if (psel && !penable)
		begin
			next_st.err = !mapped;
			if (!pwrite && paddr == OCC_ADDR_CONTROL)
				next_st.rdata = occ_image(st.ctrl);
			else if (!pwrite && paddr == OCC_ADDR_STATUS)
				next_st.rdata = {27'h000_0000, st.fsm == OCC_ST_EXT, st.fail, active.source[1:0], pll_on};
		end
		if (wr_ctrl)
		begin
			next_st.ctrl.soft_pll_enable = pwdata[OCC_POS_PLL];
			next_st.ctrl.int_osc_freq_select = pwdata[OCC_POS_FREQ_LO +: 4];
			next_st.ctrl.sysclk_source_select = pwdata[OCC_POS_SRC_LO +: 2];
		end
		// Source sequencing: internal first, external only after the timer runs out.
		unique case (st.fsm)
			OCC_ST_INT:
			begin
				if (!st.ctrl.sysclk_source_select[1] && !st.fail)
				begin
					next_st.fsm = OCC_ST_WAIT;
					next_st.startup_count = 16'h0000;
				end
			end
			OCC_ST_WAIT:
			begin
				if (st.startup_count == STARTUP_LAST)
					next_st.fsm = OCC_ST_EXT;
				else
					next_st.startup_count = st.startup_count + 16'h0001;
				if (st.ctrl.sysclk_source_select[1])
					next_st.fsm = OCC_ST_INT;
			end
			OCC_ST_EXT:
			begin
				if (st.ctrl.sysclk_source_select[1] || fail_seen)
					next_st.fsm = OCC_ST_INT;
			end
		endcase
		if (fail_seen && st.fsm == OCC_ST_EXT)
			next_st.fail = 1'b1;
		else if (src_change)
			next_st.fail = 1'b0;
		// A write that changes the source restarts the timer from the internal clock.
		if (src_change)
		begin
			next_st.fsm = OCC_ST_INT;
			next_st.startup_count = 16'h0000;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st.ctrl.soft_pll_enable <= RST_SOFT_PLL;
			st.ctrl.int_osc_freq_select <= RST_FREQ_SEL;
			st.ctrl.sysclk_source_select <= RST_SRC_SEL;
			st.fsm <= OCC_ST_INT;
			st.startup_count <= 16'h0000;
			st.fail <= 1'b0;
			st.fail_sync <= 3'h0;
			st.rdata <= 32'h0000_0000;
			st.err <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// Clock request and outputs
	// ---------------------------------------------------------------
	// The multiplier acts only on the 8 MHz high code, giving 32 MHz, or on the external source.
	always_comb
	begin
		req.freq_code = st.ctrl.int_osc_freq_select;
		req.pll_on = pll_on && (st.fsm == OCC_ST_EXT || st.ctrl.int_osc_freq_select == 4'he);
		if (st.fsm == OCC_ST_EXT)
			req.source = CLK_EXT;
		else
			req.source = occ_osc_of(st.ctrl.int_osc_freq_select);
	end

	occ_clk_switch u_switch (
		.core_clk(core_clk),
		.rst(rst),
		.req(req),
		.active(active),
		.gate_off(clk_gate_off)
	);

	assign prdata = st.rdata;
	assign pslverr = st.err;
	assign times_four_multiplier = active.pll_on;
	assign clk_source = active.source;
	assign clk_freq_code = active.freq_code;
	assign clk_mode = config_osc_mode;
	assign osc_fail_flag = st.fail;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_src_write;
		wr_ctrl && src_change;
	endsequence

	a_pll_forced: assert property (@(posedge core_clk) disable iff (rst)
		config_pll_force |-> pll_on) else $error("forced PLL not on");
	a_pll_soft: assert property (@(posedge core_clk) disable iff (rst)
		!config_pll_force |-> pll_on == st.ctrl.soft_pll_enable) else $error("PLL does not follow bit");
	a_low_code: assert property (@(posedge core_clk) disable iff (rst)
		st.fsm != OCC_ST_EXT && st.ctrl.int_osc_freq_select[3:1] == 3'h0 |-> req.source == CLK_LOW_31K)
		else $error("000x not low oscillator");
	a_mid_code: assert property (@(posedge core_clk) disable iff (rst)
		st.fsm != OCC_ST_EXT && st.ctrl.int_osc_freq_select[3:1] == 3'h1 |-> req.source == CLK_MED)
		else $error("001x not medium oscillator");
	a_high_code: assert property (@(posedge core_clk) disable iff (rst)
		st.fsm != OCC_ST_EXT && st.ctrl.int_osc_freq_select inside {4'hb, 4'hc} |-> req.source == CLK_HIGH)
		else $error("1011/1100 not high oscillator");
	a_pll_code: assert property (@(posedge core_clk) disable iff (rst)
		st.fsm != OCC_ST_EXT && req.pll_on |-> st.ctrl.int_osc_freq_select == 4'he)
		else $error("multiplier on wrong code");
	a_reset_freq: assert property (@(posedge core_clk)
		$past(rst) |-> st.ctrl.int_osc_freq_select == RST_FREQ_SEL && st.ctrl.sysclk_source_select == RST_SRC_SEL)
		else $error("bad reset value");
	a_int_select: assert property (@(posedge core_clk) disable iff (rst)
		st.ctrl.sysclk_source_select[1] |=> st.fsm != OCC_ST_EXT) else $error("1x not internal");
	a_bit2_zero: assert property (@(posedge core_clk) disable iff (rst)
		$past(psel && !penable && paddr == OCC_ADDR_CONTROL && !pwrite) |-> prdata[2] == 1'b0)
		else $error("bit 2 not zero");
	a_timer_restart: assert property (@(posedge core_clk) disable iff (rst)
		s_src_write |=> st.fsm == OCC_ST_INT ##1 st.fsm != OCC_ST_EXT) else $error("timer not restarted");
	a_fail_back: assert property (@(posedge core_clk) disable iff (rst)
		st.fsm == OCC_ST_EXT && fail_seen && !src_change |=> st.fsm == OCC_ST_INT && st.fail)
		else $error("no fallback on failure");

endmodule
`default_nettype wire

// *** occ_top_tb.sv ***
// Self-checking testbench for the oscillator control block, driven over APB.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module occ_top_tb
	import occ_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic config_pll_force = 1'b0;
	logic [2:0] config_osc_mode = 3'h0;
	logic ext_clk_fail = 1'b0;
	logic times_four_multiplier;
	logic [2:0] clk_source;
	logic [3:0] clk_freq_code;
	logic [2:0] clk_mode;
	logic clk_gate_off;
	logic osc_fail_flag;
	int miscompares = 0;
	int total_checks = 0;
	int gate_cnt = 0;
	logic [32:0] exp_q[$];

	// A short start-up timer keeps the run brief; the bounded source waits allow for it.
	occ_top #(.STARTUP_CYCLES(8)) dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.config_pll_force(config_pll_force), .config_osc_mode(config_osc_mode), .ext_clk_fail(ext_clk_fail),
		.times_four_multiplier(times_four_multiplier), .clk_source(clk_source), .clk_freq_code(clk_freq_code),
		.clk_mode(clk_mode), .clk_gate_off(clk_gate_off), .osc_fail_flag(osc_fail_flag));

	// Clock generator, 50 ns period.
	initial
	begin
		forever #25 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	// Compares each completed read with the oldest noted expectation.
	always @(posedge core_clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			if (exp_q.size() == 0)
				miscompares++;
			else
				`CHK({pslverr, prdata}, exp_q.pop_front())
		end
	end

	// Counts gating pulses so that every clock change can be shown to pass through a gap.
	always @(posedge core_clk)
	begin
		if (clk_gate_off === 1'b1)
			gate_cnt++;
	end

	task automatic stop_test();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog sized well above the expected run of a few hundred cycles.
	initial
	begin
		#(50 * 20000);
		miscompares++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// Bus tasks and helpers
	// ---------------------------------------------------------------
	// One APB transfer; reads note {pslverr, prdata} as the expected answer.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge core_clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	function automatic logic [31:0] ctrl(input logic pll, input logic [3:0] f, input logic [1:0] s);
		return {24'h00_0000, pll, f, 1'b0, s};
	endfunction

	// Waits a bounded time for the applied source, sampling after each edge has settled.
	task automatic wait_src(input logic [2:0] s);
		int n;
		n = 0;
		while (n < 60 && clk_source !== s)
		begin
			n++;
			@(posedge core_clk);
			#1;
		end
		`CHK(clk_source, s)
		// Settle past the edge so freshly launched outputs and the gate count are seen.
		@(posedge core_clk);
		#1;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		logic [3:0] f;
		logic [2:0] es;
		logic [31:0] r;
		int g;
		void'($urandom(21));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, OCC_ADDR_CONTROL, 32'h0, {1'b0, 32'h0000_0038});
		apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0000_0000});
		apb(1'b1, 12'h008, 32'hFFFF_FFFF, 33'h0);
		apb(1'b1, OCC_ADDR_CONTROL, 32'h0000_00FF, 33'h0);
		apb(1'b0, OCC_ADDR_CONTROL, 32'h0, {1'b0, 32'h0000_00FB});
		// Every frequency code on the internal block; low, medium and high decode checked.
		for (int i = 0; i < 16; i++)
		begin
			f = i[3:0];
			es = f[3] ? CLK_HIGH : ((f[3:1] == 3'h0) ? CLK_LOW_31K : CLK_MED);
			g = gate_cnt;
			apb(1'b1, OCC_ADDR_CONTROL, ctrl(1'b0, f, 2'b10), 33'h0);
			wait_src(es);
			`CHK(clk_freq_code, f)
			if (i > 0)
				`CHK(gate_cnt > g, 1'b1)
		end
		// Software enable, then the forcing setting.
		apb(1'b1, OCC_ADDR_CONTROL, ctrl(1'b1, 4'hE, 2'b10), 33'h0);
		repeat (4) @(posedge core_clk);
		`CHK(times_four_multiplier, 1'b1)
		apb(1'b1, OCC_ADDR_CONTROL, ctrl(1'b0, 4'hE, 2'b10), 33'h0);
		repeat (4) @(posedge core_clk);
		`CHK(times_four_multiplier, 1'b0)
		config_pll_force <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK(times_four_multiplier, 1'b1)
		config_pll_force <= 1'b0;
		// Random control values and oscillator modes.
		repeat (8)
		begin
			r = $urandom;
			config_osc_mode <= r[10:8];
			apb(1'b1, OCC_ADDR_CONTROL, r, 33'h0);
			apb(1'b0, OCC_ADDR_CONTROL, 32'h0, {1'b0, r & 32'h0000_00FB});
			`CHK(clk_mode, r[10:8])
		end
		// Start-up timer, switch to the external source, then a failure.
		apb(1'b1, OCC_ADDR_CONTROL, ctrl(1'b0, 4'hB, 2'b10), 33'h0);
		wait_src(CLK_HIGH);
		apb(1'b1, OCC_ADDR_CONTROL, ctrl(1'b0, 4'hB, 2'b00), 33'h0);
		repeat (4) @(posedge core_clk);
		`CHK(clk_source === CLK_EXT, 1'b0)
		wait_src(CLK_EXT);
		ext_clk_fail <= 1'b1;
		wait_src(CLK_HIGH);
		`CHK(osc_fail_flag, 1'b1)
		@(posedge core_clk);
		apb(1'b0, OCC_ADDR_STATUS, 32'h0, {1'b0, 32'h0000_000C});
		`CHK(clk_freq_code, 4'hB)
		ext_clk_fail <= 1'b0;
		apb(1'b1, OCC_ADDR_CONTROL, ctrl(1'b0, 4'hB, 2'b10), 33'h0);
		repeat (4) @(posedge core_clk);
		`CHK(osc_fail_flag, 1'b0)
		stop_test();
	end
endmodule
`default_nettype wire
